/* File: rtl/lss_pkg.sv */
package lss_pkg;
	localparam int NCH = 8;
	localparam int FRAME_BITS = 16;
	localparam int BIT_CNT_W = 5;
	localparam int SYS_CLK_HZ = 125_000_000;
	localparam int SCLK_MAX_HZ = 5_000_000;
	localparam int SCLK_MIN_CYC = SYS_CLK_HZ / SCLK_MAX_HZ;
	localparam int FS_RESTART_DELAY_US = 1000;
	localparam int FS_RESTART_CYC =
		FS_RESTART_DELAY_US * (SYS_CLK_HZ / 1_000_000);
	localparam int RST_CNT_W = 17;
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_MAP0 = 3'h1;
	localparam logic [2:0] ADDR_MAP1 = 3'h2;
	localparam logic [2:0] ADDR_OLC = 3'h3;
	localparam logic [2:0] ADDR_CFG = 3'h4;
	localparam logic [2:0] ADDR_OVL = 3'h5;
	localparam logic [2:0] ADDR_OT = 3'h6;
	localparam logic [2:0] ADDR_OSM = 3'h7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MAP0_RST = 8'h04;
	localparam logic [7:0] MAP1_RST = 8'h08;
	localparam logic [7:0] OLC_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam int CFG_FS_BIT = 0;
	localparam int FS_CH_IN0 = 2;
	localparam int FS_CH_IN1 = 3;
	typedef struct packed {
		logic wr;
		logic [2:0] addr;
		logic [3:0] rsvd;
		logic [7:0] data;
	} lss_frame_t;
	typedef struct packed {
		logic in1;
		logic in0;
		logic fs;
		logic [2:0] addr;
		logic [1:0] rsvd;
		logic [7:0] data;
	} lss_resp_t;
	typedef struct packed {
		logic vdd;
		logic idle;
		logic in1;
		logic in0;
		logic [7:0] ovl;
		logic [7:0] ot;
		logic [7:0] sense;
	} lss_pins_t;
endpackage : lss_pkg

/* File: rtl/lss_spi_shift.sv */
`timescale 1ns/1ps
`default_nettype none
module lss_spi_shift (
	input wire logic sys_clk, // system clock
	input wire logic resetn, // sync reset, active low
	input wire logic spi_cs_n, // chip select pin
	input wire logic spi_sclk, // serial clock pin
	input wire logic spi_mosi, // serial data in pin
	input wire logic vdd_ok, // digital supply present
	input wire lss_pkg::lss_resp_t tx_word, // answer for next frame
	output lss_pkg::lss_frame_t rx_frame, // last 16 bits received
	output logic rx_valid, // one-cycle pulse per frame
	output logic spi_miso, // serial data out
	output logic spi_miso_oe_n // low while driving data out
);
	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic sclk_d_ff;
	logic cs_d_ff;
	logic [lss_pkg::FRAME_BITS-1:0] sr_ff;
	logic [lss_pkg::BIT_CNT_W-1:0] cnt_ff;
	logic full_ff;
	logic sclk_s;
	logic cs_s;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	assign sclk_s = sync_ff[2];
	assign cs_s = sync_ff[1];
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign cs_fall = ~cs_s & cs_d_ff;
	assign cs_rise = cs_s & ~cs_d_ff;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			meta_ff <= 3'h2;
			sync_ff <= 3'h2;
			sclk_d_ff <= 1'b0;
			cs_d_ff <= 1'b1;
		end
		else
		begin
			meta_ff <= {spi_sclk, spi_cs_n, spi_mosi};
			sync_ff <= meta_ff;
			sclk_d_ff <= sclk_s;
			cs_d_ff <= cs_s;
		end
	end

	// one shift chain: bits leave 16 clocks after entering
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			sr_ff <= 16'h0000;
			spi_miso <= 1'b0;
		end
		else if (cs_fall)
		begin
			sr_ff <= tx_word;
			spi_miso <= tx_word[lss_pkg::FRAME_BITS-1];
		end
		else if (!cs_s && sclk_rise)
			sr_ff <= {sr_ff[lss_pkg::FRAME_BITS-2:0], sync_ff[0]};
		else if (!cs_s && sclk_fall)
			spi_miso <= sr_ff[lss_pkg::FRAME_BITS-1];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			cnt_ff <= 5'h00;
			full_ff <= 1'b0;
		end
		else if (cs_fall)
		begin
			cnt_ff <= 5'h00;
			full_ff <= 1'b0;
		end
		else if (!cs_s && sclk_rise)
		begin
			cnt_ff <= cnt_ff + 5'h01;
			if (cnt_ff == 5'h0f)
				full_ff <= 1'b1;
		end
	end

	// accept whole multiples of 8 bits, at least 16
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rx_frame <= '0;
			rx_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= cs_rise & full_ff & vdd_ok &
				(cnt_ff[2:0] == 3'h0);
			if (cs_rise)
				rx_frame <= sr_ff;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			spi_miso_oe_n <= 1'b1;
		else
			spi_miso_oe_n <= cs_s | ~vdd_ok;
	end
endmodule : lss_spi_shift
`default_nettype wire

/* File: rtl/lss_switch_ctrl.sv */
// Notes on behaviour
// - control and diagnosis use 16-bit serial frames.
// - frames daisy-chain; multiples of 8 bits accepted, last 16 used.
// - serial clock up to 5 MHz; sampled by the system clock.
// - eight channels, each with own on/off control and diagnosis.
// - after reset input zero drives channel 2, input one channel 3.
// - programmable map lets each input drive any set of channels.
// - fail-safe mode routes inputs straight to channels 2 and 3.
// - with idle low, fail-safe channels follow inputs without supply.
// - serial access takes effect only while digital supply present.
// - overload latches channel off until host clears it.
// - in fail-safe, latched channel with high input restarts after delay.
// - per-channel over-temperature latches the channel off.
// - diagnostic events latched and readable over serial link.
// - output status monitor bits report sensed output state.
// - open-load test current only when host enables it.
// - serial output undriven while chip select is high.
// - idle pin high selects idle power mode; pin defaults low.
`timescale 1ns/1ps
`default_nettype none
module lss_switch_ctrl #(
	parameter int RESTART_CYCLES = lss_pkg::FS_RESTART_CYC
) (
	input wire logic sys_clk, // 125 MHz system clock
	input wire logic resetn, // sync reset, active low
	input wire logic spi_cs_n, // chip select, active low
	input wire logic spi_sclk, // serial clock
	input wire logic spi_mosi, // serial data in
	output logic spi_miso, // serial data out
	output logic spi_miso_oe_n, // low while data out driven
	input wire logic vdd_present, // digital supply good
	input wire logic idle_pin, // idle mode request
	input wire logic parallel_input_zero, // direct input 0
	input wire logic parallel_input_one, // direct input 1
	input wire logic [7:0] overload_trip_current, // overload sense
	input wire logic [7:0] over_temp, // per-channel thermal trip
	input wire logic [7:0] output_sense, // sensed output level
	output logic [7:0] chan_on, // gate drive per channel
	output logic [7:0] open_load_test_current, // test source enables
	output logic idle_mode, // idle power mode active
	output logic fail_safe_active // fail-safe routing active
);
	localparam int N = lss_pkg::NCH;
	localparam logic [lss_pkg::RST_CNT_W-1:0] RST_LAST =
		lss_pkg::RST_CNT_W'(RESTART_CYCLES - 1);

	lss_pkg::lss_pins_t pins_raw;
	lss_pkg::lss_pins_t pin_meta_ff;
	lss_pkg::lss_pins_t pin_ff;
	lss_pkg::lss_frame_t rx_frame;
	lss_pkg::lss_resp_t tx_word;
	logic rx_valid;
	logic [7:0] ctrl_ff;
	logic [7:0] map0_ff;
	logic [7:0] map1_ff;
	logic [7:0] olc_en_ff;
	logic [7:0] cfg_ff;
	logic [2:0] rd_addr_ff;
	logic [7:0] ovl_lat_ff;
	logic [7:0] ot_lat_ff;
	logic [7:0] osm_ff;
	logic [7:0] fs_req;
	logic [7:0] map_req;
	logic [7:0] req;
	logic [7:0] restart;
	logic [7:0] nxt_on;
	logic fs_mode;
	logic sleep;
	logic wr_ovl;
	logic wr_ot;

	function automatic logic [7:0] read_reg(
		input logic [2:0] a,
		input logic [7:0] c,
		input logic [7:0] m0,
		input logic [7:0] m1,
		input logic [7:0] olc,
		input logic [7:0] cfg,
		input logic [7:0] ovl,
		input logic [7:0] ot,
		input logic [7:0] osm
	);
		case (a)
			lss_pkg::ADDR_CTRL: read_reg = c;
			lss_pkg::ADDR_MAP0: read_reg = m0;
			lss_pkg::ADDR_MAP1: read_reg = m1;
			lss_pkg::ADDR_OLC: read_reg = olc;
			lss_pkg::ADDR_CFG: read_reg = cfg;
			lss_pkg::ADDR_OVL: read_reg = ovl;
			lss_pkg::ADDR_OT: read_reg = ot;
			default: read_reg = osm;
		endcase
	endfunction : read_reg

	assign pins_raw.vdd = vdd_present;
	assign pins_raw.idle = idle_pin;
	assign pins_raw.in1 = parallel_input_one;
	assign pins_raw.in0 = parallel_input_zero;
	assign pins_raw.ovl = overload_trip_current;
	assign pins_raw.ot = over_temp;
	assign pins_raw.sense = output_sense;

	// two-stage synchroniser for every pin input
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			pin_meta_ff <= '0;
			pin_ff <= '0;
		end
		else
		begin
			pin_meta_ff <= pins_raw;
			pin_ff <= pin_meta_ff;
		end
	end

	lss_spi_shift u_spi (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi),
		.vdd_ok(pin_ff.vdd),
		.tx_word(tx_word),
		.rx_frame(rx_frame),
		.rx_valid(rx_valid),
		.spi_miso(spi_miso),
		.spi_miso_oe_n(spi_miso_oe_n)
	);

	// register writes; rx_valid never fires without supply
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			ctrl_ff <= lss_pkg::CTRL_RST;
			map0_ff <= lss_pkg::MAP0_RST;
			map1_ff <= lss_pkg::MAP1_RST;
			olc_en_ff <= lss_pkg::OLC_RST;
			cfg_ff <= lss_pkg::CFG_RST;
		end
		else if (rx_valid && rx_frame.wr)
		begin
			case (rx_frame.addr)
				lss_pkg::ADDR_CTRL: ctrl_ff <= rx_frame.data;
				lss_pkg::ADDR_MAP0: map0_ff <= rx_frame.data;
				lss_pkg::ADDR_MAP1: map1_ff <= rx_frame.data;
				lss_pkg::ADDR_OLC: olc_en_ff <= rx_frame.data;
				lss_pkg::ADDR_CFG: cfg_ff <= rx_frame.data;
				default: ;
			endcase
		end
	end

	// answer of the next frame follows this frame's address
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			rd_addr_ff <= lss_pkg::ADDR_OSM;
		else if (rx_valid)
			rd_addr_ff <= rx_frame.addr;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			osm_ff <= 8'h00;
		else
			osm_ff <= pin_ff.sense;
	end

	always_comb
	begin
		tx_word.in1 = pin_ff.in1;
		tx_word.in0 = pin_ff.in0;
		tx_word.fs = fs_mode;
		tx_word.addr = rd_addr_ff;
		tx_word.rsvd = 2'h0;
		tx_word.data = read_reg(rd_addr_ff, ctrl_ff, map0_ff,
			map1_ff, olc_en_ff, cfg_ff, ovl_lat_ff, ot_lat_ff,
			osm_ff);
	end

	assign fs_mode = ~pin_ff.vdd | cfg_ff[lss_pkg::CFG_FS_BIT];
	assign sleep = pin_ff.idle & ~pin_ff.vdd;
	assign wr_ovl = rx_valid & rx_frame.wr &
		(rx_frame.addr == lss_pkg::ADDR_OVL);
	assign wr_ot = rx_valid & rx_frame.wr &
		(rx_frame.addr == lss_pkg::ADDR_OT);

	always_comb
	begin
		fs_req = 8'h00;
		fs_req[lss_pkg::FS_CH_IN0] = pin_ff.in0;
		fs_req[lss_pkg::FS_CH_IN1] = pin_ff.in1;
		map_req = ({N{pin_ff.in0}} & map0_ff) |
			({N{pin_ff.in1}} & map1_ff);
		req = fs_mode ? fs_req : (ctrl_ff | map_req);
		nxt_on = req & ~ovl_lat_ff & ~ot_lat_ff &
			{N{~sleep}};
	end

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_ch
			logic [lss_pkg::RST_CNT_W-1:0] rst_cnt_ff;

			// retry timer, only while fail-safe and input high
			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
					rst_cnt_ff <= '0;
				else if (fs_mode && ovl_lat_ff[i] && fs_req[i]
					&& rst_cnt_ff != RST_LAST)
					rst_cnt_ff <= rst_cnt_ff + 1'b1;
				else
					rst_cnt_ff <= '0;
			end
			assign restart[i] = fs_mode & ovl_lat_ff[i] & fs_req[i] &
				(rst_cnt_ff == RST_LAST);

			// set wins over host clear and retry
			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
					ovl_lat_ff[i] <= 1'b0;
				else if (pin_ff.ovl[i] && chan_on[i])
					ovl_lat_ff[i] <= 1'b1;
				else if ((wr_ovl && rx_frame.data[i]) || restart[i])
					ovl_lat_ff[i] <= 1'b0;
			end

			always_ff @(posedge sys_clk)
			begin
				if (!resetn)
					ot_lat_ff[i] <= 1'b0;
				else if (pin_ff.ot[i])
					ot_lat_ff[i] <= 1'b1;
				else if (wr_ot && rx_frame.data[i])
					ot_lat_ff[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			chan_on <= 8'h00;
		else
			chan_on <= nxt_on;
	end

	// test source only with channel off and supply present
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			open_load_test_current <= 8'h00;
		else
			open_load_test_current <= olc_en_ff & ~nxt_on &
				{N{pin_ff.vdd}};
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			idle_mode <= 1'b0;
			fail_safe_active <= 1'b0;
		end
		else
		begin
			idle_mode <= pin_ff.idle;
			fail_safe_active <= fs_mode;
		end
	end
endmodule : lss_switch_ctrl
`default_nettype wire

/* File: verification/lss_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lss_ctrl_sva (
	input wire logic sys_clk, // clock
	input wire logic resetn, // reset
	input wire logic spi_cs_n, // select
	input wire logic spi_miso_oe_n, // out enable
	input wire logic vdd_present, // supply
	input wire logic idle_pin, // idle pin
	input wire logic [7:0] overload_trip_current, // overload
	input wire logic [7:0] over_temp, // thermal
	input wire logic [7:0] chan_on, // drive
	input wire logic [7:0] open_load_test_current, // test source
	input wire logic idle_mode, // idle
	input wire logic fail_safe_active // fail-safe
);
	default clocking dcb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	sequence s_trip;
		(|(chan_on & overload_trip_current)) [*3];
	endsequence
	sequence s_heat;
		(|(chan_on & over_temp)) [*3];
	endsequence
	property p_ovl;
		s_trip |-> ##[0:3] !(|(chan_on & overload_trip_current));
	endproperty
	a_ovl: assert property (p_ovl) else $error("ovl left on");
	property p_ot;
		s_heat |-> ##[0:3] !(|(chan_on & over_temp));
	endproperty
	a_ot: assert property (p_ot) else $error("hot left on");
	property p_oe;
		spi_cs_n [*5] |-> spi_miso_oe_n;
	endproperty
	a_oe: assert property (p_oe) else $error("out driven");
	property p_fs;
		!vdd_present [*5] |-> fail_safe_active;
	endproperty
	a_fs: assert property (p_fs) else $error("no fail-safe");
	property p_fs_ch;
		fail_safe_active [*3] |-> (chan_on & 8'hf3) == 8'h00;
	endproperty
	a_fs_ch: assert property (p_fs_ch) else $error("bad route");
	property p_idle;
		idle_pin [*4] |-> idle_mode;
	endproperty
	a_idle: assert property (p_idle) else $error("no idle");
	property p_sleep;
		(idle_pin && !vdd_present) [*5] |-> chan_on == 8'h00;
	endproperty
	a_sleep: assert property (p_sleep) else $error("on in sleep");
	property p_olc;
		(open_load_test_current & chan_on) == 8'h00;
	endproperty
	a_olc: assert property (p_olc) else $error("source on");
endmodule : lss_ctrl_sva
bind lss_switch_ctrl lss_ctrl_sva u_lss_ctrl_sva (.sys_clk(sys_clk),
	.resetn(resetn), .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n),
	.vdd_present(vdd_present), .idle_pin(idle_pin),
	.overload_trip_current(overload_trip_current), .over_temp(over_temp),
	.chan_on(chan_on), .open_load_test_current(open_load_test_current),
	.idle_mode(idle_mode), .fail_safe_active(fail_safe_active));
`default_nettype wire

/* File: verification/lss_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lss_host_model (
	output logic spi_cs_n, // select
	output logic spi_sclk, // clock, low outside frames
	output logic spi_mosi, // to device
	input wire logic spi_miso, // from device
	input wire logic spi_miso_oe_n // device drives when low
);
	logic last = 1'b0;
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
	end
	// mode 0, msb first, 5 MHz
	task automatic xfer(input int n, input logic [31:0] tx,
		output logic [31:0] rx);
		rx = 32'h0000_0000;
		spi_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			spi_mosi = tx[i];
			#100;
			spi_sclk = 1'b1;
			last = spi_miso_oe_n ? ~last : spi_miso;
			rx[i] = last;
			#100;
			spi_sclk = 1'b0;
		end
		#100;
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#200;
	endtask : xfer
endmodule : lss_host_model
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("BAD %s exp %h got %h", nm, e, g); \
		end \
	end
module testbench;
	typedef struct packed {
		logic [1:0] sel;
		logic [15:0] exp;
	} lss_note_t;
	logic sys_clk = 1'b0, resetn = 1'b0, vdd = 1'b1, idle = 1'b0;
	logic in_zero = 1'b0, in_one = 1'b0;
	logic [7:0] ovl = 8'h00, ot = 8'h00, sense = 8'h00, map_r;
	logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe_n;
	logic [7:0] chan_on, olc;
	logic idle_mode, fs_act;
	logic [15:0] rx_word = 16'h0000;
	logic [31:0] seed = 32'h0000_ab6d;
	int n_mismatch = 0, comparisons = 0;
	string nm[4] = '{"chan_on", "rx_word", "olc", "status"};
	lss_note_t q[$];
	lss_note_t nt;
	always #4 sys_clk = ~sys_clk;
	lss_host_model u_lss_host_model (.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe_n(spi_miso_oe_n));
	lss_switch_ctrl #(.RESTART_CYCLES(20)) u_lss_switch_ctrl (
		.sys_clk(sys_clk), .resetn(resetn), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe_n(spi_miso_oe_n), .vdd_present(vdd), .idle_pin(idle),
		.parallel_input_zero(in_zero), .parallel_input_one(in_one),
		.overload_trip_current(ovl), .over_temp(ot), .output_sense(sense),
		.chan_on(chan_on), .open_load_test_current(olc),
		.idle_mode(idle_mode), .fail_safe_active(fs_act));
	function automatic logic [31:0] rnd(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : rnd
	function automatic logic [15:0] out(input logic [1:0] s);
		case (s)
			2'h0: return {8'h00, chan_on};
			2'h1: return rx_word;
			2'h2: return {8'h00, olc};
			default: return {14'h0000, idle_mode, fs_act};
		endcase
	endfunction : out
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	// monitor: oldest note against the outputs
	always @(posedge sys_clk)
		if (q.size() > 0)
		begin
			nt = q.pop_front();
			`CHK(nm[nt.sel], nt.exp, out(nt.sel))
		end
	task automatic ex(input logic [1:0] s, input logic [15:0] e);
		int k;
		for (k = 0; k < 60; k++)
		begin
			@(negedge sys_clk);
			if (out(s) === e)
				break;
		end
		q.push_back({s, e});
		@(posedge sys_clk);
		if (k == 60)
		begin
			n_mismatch++;
			final_report();
		end
	endtask : ex
	task automatic sx(input int n, input logic [31:0] tx);
		logic [31:0] r;
		u_lss_host_model.xfer(n, tx, r);
		rx_word = r[15:0];
		@(posedge sys_clk);
	endtask : sx
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		sx(16, {16'h0000, 1'b1, a, 4'h0, d});
	endtask : wr
	task automatic rd(input logic [2:0] a);
		sx(16, {16'h0000, 1'b0, a, 12'h000});
	endtask : rd
	initial
	begin
		seed = rnd(seed);
		sense = seed[7:0];
		seed = rnd(seed);
		map_r = seed[7:0];
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ex(2'h0, 16'h0000);
		in_zero <= 1'b1;
		ex(2'h0, 16'h0004);
		in_one <= 1'b1;
		ex(2'h0, 16'h000c);
		in_one <= 1'b0;
		wr(lss_pkg::ADDR_MAP0, map_r);
		ex(2'h0, {8'h00, map_r});
		in_zero <= 1'b0;
		sx(24, {8'h00, 8'ha5, 1'b1, lss_pkg::ADDR_CTRL, 4'h0, 8'h01});
		ex(2'h0, 16'h0001);
		// short frame would write ff if taken
		sx(15, {17'h0_0000, 15'h00ff});
		ex(2'h0, 16'h0001);
		rd(lss_pkg::ADDR_OSM);
		rd(lss_pkg::ADDR_OSM);
		ex(2'h1, {3'h0, lss_pkg::ADDR_OSM, 2'h0, sense});
		wr(lss_pkg::ADDR_OLC, 8'hff);
		ex(2'h2, 16'h00fe);
		ovl <= 8'h01;
		ex(2'h0, 16'h0000);
		ovl <= 8'h00;
		repeat (30) @(posedge sys_clk);
		ex(2'h0, 16'h0000);
		wr(lss_pkg::ADDR_OVL, 8'h01);
		ex(2'h0, 16'h0001);
		ot <= 8'h01;
		ex(2'h0, 16'h0000);
		ot <= 8'h00;
		wr(lss_pkg::ADDR_OT, 8'h01);
		ex(2'h0, 16'h0001);
		vdd <= 1'b0;
		in_zero <= 1'b1;
		in_one <= 1'b1;
		ex(2'h3, 16'h0001);
		ex(2'h0, 16'h000c);
		wr(lss_pkg::ADDR_CTRL, 8'hff);
		ex(2'h2, 16'h0000);
		vdd <= 1'b1;
		ex(2'h0, {8'h00, map_r | 8'h09});
		in_zero <= 1'b0;
		in_one <= 1'b0;
		idle <= 1'b1;
		vdd <= 1'b0;
		ex(2'h3, 16'h0003);
		ex(2'h0, 16'h0000);
		idle <= 1'b0;
		vdd <= 1'b1;
		wr(lss_pkg::ADDR_CFG, 8'h01);
		in_zero <= 1'b1;
		ex(2'h0, 16'h0004);
		ovl <= 8'h04;
		repeat (6) @(posedge sys_clk);
		ovl <= 8'h00;
		ex(2'h0, 16'h0000);
		ex(2'h0, 16'h0004);
		final_report();
	end
endmodule : testbench
`default_nettype wire
